// >>> pkg/rtse_pkg.sv
// Register map, field layout and reset values of the radio task subscription bank
package rtse_pkg;
    localparam int unsigned NUM_TASKS = 12;

    localparam logic [11:0] OFF_RX_ENABLE_SUB       = 12'h0084;
    localparam logic [11:0] OFF_START_SUB           = 12'h0088;
    localparam logic [11:0] OFF_STOP_SUB            = 12'h008C;
    localparam logic [11:0] OFF_DISABLE_SUB         = 12'h0090;
    localparam logic [11:0] OFF_STRENGTH_START_SUB  = 12'h0094;
    localparam logic [11:0] OFF_STRENGTH_STOP_SUB   = 12'h0098;
    localparam logic [11:0] OFF_BITCOUNT_START_SUB  = 12'h009C;
    localparam logic [11:0] OFF_BITCOUNT_STOP_SUB   = 12'h00A0;
    localparam logic [11:0] OFF_ENERGY_START_SUB    = 12'h00A4;
    localparam logic [11:0] OFF_ENERGY_STOP_SUB     = 12'h00A8;
    localparam logic [11:0] OFF_CHCHECK_START_SUB   = 12'h00AC;
    localparam logic [11:0] OFF_CHCHECK_STOP_SUB    = 12'h00B0;
    localparam logic [11:0] OFF_SUB_FIRST           = OFF_RX_ENABLE_SUB;
    localparam logic [11:0] OFF_SUB_LAST            = OFF_CHCHECK_STOP_SUB;
    localparam logic [11:0] OFF_RAMPUP_DONE_EVENT   = 12'h0100;
    localparam logic [11:0] OFF_ADDRESS_PASSED_EVENT = 12'h0104;
    localparam logic [11:0] OFF_INT_STATUS          = 12'h0300;
    localparam logic [11:0] OFF_INT_MASK            = 12'h0304;

    localparam int unsigned CHANNEL_INDEX_LSB = 0;
    localparam int unsigned CHANNEL_INDEX_W   = 8;
    localparam int unsigned SUB_ENABLE_BIT    = 31;
    localparam int unsigned EVENT_FLAG_BIT    = 0;
    localparam int unsigned INT_RAMPUP_BIT    = 0;
    localparam int unsigned INT_ADDRESS_BIT   = 1;
    localparam int unsigned INT_W             = 2;

    localparam logic [31:0] SUB_RESET   = 32'h0000_0000;
    localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
endpackage : rtse_pkg

// >>> verilog/rtse_bank.sv
// APB register bank: task subscriptions, event flags and interrupt logic
//
// Chosen here: register access over APB.
`timescale 1ns/10ps

module rtse_bank (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_B,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Event interconnect channels, one-cycle pulses on the block clock
    input  wire logic [255:0] CHANNEL_PULSE,
    // Radio core event pulses
    input  wire logic        RAMPUP_DONE,
    input  wire logic        ADDRESS_PASSED,
    // Task triggers, one-cycle pulses in task order
    output logic [11:0]      TASK_TRIGGER,
    // Interrupt
    output logic             IRQ
);

    typedef struct packed {
        logic [rtse_pkg::NUM_TASKS-1:0][31:0] sub;
        logic                                 rampup_flag;
        logic                                 address_flag;
        logic [rtse_pkg::INT_W-1:0]           int_status;
        logic [rtse_pkg::INT_W-1:0]           int_mask;
        logic [rtse_pkg::NUM_TASKS-1:0]       trigger;
        logic [31:0]                          prdata;
        logic                                 pready;
        logic                                 pslverr;
        logic                                 irq;
    } rtse_state_t;

    rtse_state_t st;
    rtse_state_t next_st;

    logic        setup;
    logic        wr;
    logic [3:0]  task_idx;
    logic        sub_hit;
    logic [11:0] sub_rel;

    assign setup   = PSEL && !PENABLE;
    assign wr      = PSEL && PENABLE && PWRITE && st.pready;
    assign sub_rel = PADDR - rtse_pkg::OFF_SUB_FIRST;
    assign task_idx = sub_rel[5:2];
    assign sub_hit = (PADDR[1:0] == 2'b00) && (PADDR >= rtse_pkg::OFF_SUB_FIRST)
                     && (PADDR <= rtse_pkg::OFF_SUB_LAST);

    always_comb begin
        logic [rtse_pkg::INT_W-1:0] ev;
        logic [7:0]                 chan;
        next_st = st;
        ev      = {ADDRESS_PASSED, RAMPUP_DONE};
        chan    = 8'h00;
        // Answer one cycle after setup so each access takes exactly two cycles
        next_st.pready  = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h0000_0000;
        if (setup) begin
            if (sub_hit) begin
                next_st.prdata = st.sub[task_idx];
            end else if (PADDR == rtse_pkg::OFF_RAMPUP_DONE_EVENT) begin
                next_st.prdata[rtse_pkg::EVENT_FLAG_BIT] = st.rampup_flag;
            end else if (PADDR == rtse_pkg::OFF_ADDRESS_PASSED_EVENT) begin
                next_st.prdata[rtse_pkg::EVENT_FLAG_BIT] = st.address_flag;
            end else if (PADDR == rtse_pkg::OFF_INT_STATUS) begin
                next_st.prdata[rtse_pkg::INT_W-1:0] = st.int_status;
            end else if (PADDR == rtse_pkg::OFF_INT_MASK) begin
                next_st.prdata[rtse_pkg::INT_W-1:0] = st.int_mask;
            end else begin
                // Unmapped addresses read zero and report an error
                next_st.pslverr = 1'b1;
            end
        end
        if (wr) begin
            if (sub_hit) begin
                // Only channel index and enable are stored; other bits read zero
                next_st.sub[task_idx] = 32'h0000_0000;
                next_st.sub[task_idx][rtse_pkg::CHANNEL_INDEX_W-1:0] =
                    PWDATA[rtse_pkg::CHANNEL_INDEX_W-1:0];
                next_st.sub[task_idx][rtse_pkg::SUB_ENABLE_BIT] =
                    PWDATA[rtse_pkg::SUB_ENABLE_BIT];
            end else if (PADDR == rtse_pkg::OFF_RAMPUP_DONE_EVENT) begin
                next_st.rampup_flag = PWDATA[rtse_pkg::EVENT_FLAG_BIT];
            end else if (PADDR == rtse_pkg::OFF_ADDRESS_PASSED_EVENT) begin
                next_st.address_flag = PWDATA[rtse_pkg::EVENT_FLAG_BIT];
            end else if (PADDR == rtse_pkg::OFF_INT_STATUS) begin
                next_st.int_status = st.int_status & ~PWDATA[rtse_pkg::INT_W-1:0];
            end else if (PADDR == rtse_pkg::OFF_INT_MASK) begin
                next_st.int_mask = PWDATA[rtse_pkg::INT_W-1:0];
            end
        end
        // Hardware set wins over a software clear in the same cycle
        if (RAMPUP_DONE) begin
            next_st.rampup_flag = 1'b1;
        end
        if (ADDRESS_PASSED) begin
            next_st.address_flag = 1'b1;
        end
        next_st.int_status = next_st.int_status | ev;
        for (int i = 0; i < rtse_pkg::NUM_TASKS; i++) begin
            chan = st.sub[i][rtse_pkg::CHANNEL_INDEX_W-1:0];
            next_st.trigger[i] = st.sub[i][rtse_pkg::SUB_ENABLE_BIT]
                                 && CHANNEL_PULSE[chan];
        end
        next_st.irq = |(next_st.int_status & next_st.int_mask);
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            st <= '0;
            for (int i = 0; i < rtse_pkg::NUM_TASKS; i++) begin
                st.sub[i] <= rtse_pkg::SUB_RESET;
            end
            st.int_mask <= rtse_pkg::MASK_RESET[rtse_pkg::INT_W-1:0];
        end else begin
            st <= next_st;
        end
    end

    assign PRDATA       = st.prdata;
    assign PREADY       = st.pready;
    assign PSLVERR      = st.pslverr;
    assign TASK_TRIGGER = st.trigger;
    assign IRQ          = st.irq;

    // Assertions
    sequence s_sub_armed(int k);
        st.sub[k][rtse_pkg::SUB_ENABLE_BIT]
            && CHANNEL_PULSE[st.sub[k][rtse_pkg::CHANNEL_INDEX_W-1:0]];
    endsequence

    a_task_trigger_fire: assert property (
        @(posedge CLK) disable iff (!RST_B)
        s_sub_armed(0) |=> TASK_TRIGGER[0])
        else $error("Armed subscription did not trigger task");
    a_task_trigger_quiet: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !st.sub[1][rtse_pkg::SUB_ENABLE_BIT] |=> !TASK_TRIGGER[1])
        else $error("Disabled subscription triggered task");
    a_sub_upper_zero: assert property (
        @(posedge CLK) disable iff (!RST_B)
        st.sub[2][30:rtse_pkg::CHANNEL_INDEX_W] == '0)
        else $error("Unused subscription bits not zero");
    a_sub_reset_zero: assert property (
        @(posedge CLK) $rose(RST_B) |-> st.sub == '0)
        else $error("Subscription not zero after reset");
    a_rampup_flag_set: assert property (
        @(posedge CLK) disable iff (!RST_B)
        RAMPUP_DONE |=> st.rampup_flag)
        else $error("Ramp-up flag not set");
    a_address_flag_set: assert property (
        @(posedge CLK) disable iff (!RST_B)
        ADDRESS_PASSED |=> st.address_flag)
        else $error("Address flag not set");
    a_flag_no_spurious: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !st.rampup_flag && !RAMPUP_DONE && !wr |=> !st.rampup_flag)
        else $error("Ramp-up flag rose without event");
    a_sub_write_store: assert property (
        @(posedge CLK) disable iff (!RST_B)
        wr && sub_hit |=> st.sub[$past(task_idx)][7:0] == $past(PWDATA[7:0]))
        else $error("Subscription write not stored");
    a_apb_two_cycle: assert property (
        @(posedge CLK) disable iff (!RST_B)
        setup |=> PREADY ##1 !PREADY)
        else $error("APB answer not one cycle after setup");

    // Timing used throughout: a setup cycle is answered at the next edge,
    // a write lands at the edge where PREADY is seen high, and a trigger
    // follows its channel pulse by exactly one cycle
    sequence s_sub_write(int k);
        wr && sub_hit && (task_idx == 4'(k));
    endsequence

    sequence s_sub_read(int k);
        setup && sub_hit && (task_idx == 4'(k));
    endsequence

    sequence s_flag_read(logic [11:0] addr);
        setup && (PADDR == addr);
    endsequence

    sequence s_rampup_clear;
        wr && (PADDR == rtse_pkg::OFF_RAMPUP_DONE_EVENT)
            && !PWDATA[rtse_pkg::EVENT_FLAG_BIT] && !RAMPUP_DONE;
    endsequence

    sequence s_address_clear;
        wr && (PADDR == rtse_pkg::OFF_ADDRESS_PASSED_EVENT)
            && !PWDATA[rtse_pkg::EVENT_FLAG_BIT] && !ADDRESS_PASSED;
    endsequence

    // All twelve subscriptions share one layout, so the task 0, 1 and 2
    // checks are repeated for every task here; a stuck bit in the index
    // decode would otherwise hide behind the registers a short test never uses
    for (genvar k = 0; k < rtse_pkg::NUM_TASKS; k++) begin : g_task_chk
        a_each_trig_fire: assert property (
            @(posedge CLK) disable iff (!RST_B)
            s_sub_armed(k) |=> TASK_TRIGGER[k])
            else $error("Armed subscription did not trigger its task");

        a_each_trig_quiet: assert property (
            @(posedge CLK) disable iff (!RST_B)
            !st.sub[k][rtse_pkg::SUB_ENABLE_BIT] |=> !TASK_TRIGGER[k])
            else $error("Disabled subscription triggered its task");

        // A pulse on any channel but the selected one is ignored
        a_each_chan_select: assert property (
            @(posedge CLK) disable iff (!RST_B)
            !CHANNEL_PULSE[st.sub[k][rtse_pkg::CHANNEL_INDEX_W-1:0]]
                |=> !TASK_TRIGGER[k])
            else $error("Task triggered by an unselected channel");

        // A trigger is only ever the echo of an armed pulse one cycle earlier
        a_each_trig_cause: assert property (
            @(posedge CLK) disable iff (!RST_B)
            TASK_TRIGGER[k] |-> $past(st.sub[k][rtse_pkg::SUB_ENABLE_BIT]
                && CHANNEL_PULSE[st.sub[k][rtse_pkg::CHANNEL_INDEX_W-1:0]]))
            else $error("Task triggered without an armed pulse");

        a_each_upper_zero: assert property (
            @(posedge CLK) disable iff (!RST_B)
            st.sub[k][rtse_pkg::SUB_ENABLE_BIT-1:rtse_pkg::CHANNEL_INDEX_W] == '0)
            else $error("Unused subscription bits not zero");

        a_each_index_store: assert property (
            @(posedge CLK) disable iff (!RST_B)
            s_sub_write(k) |=> st.sub[k][rtse_pkg::CHANNEL_INDEX_W-1:0]
                == $past(PWDATA[rtse_pkg::CHANNEL_INDEX_W-1:0]))
            else $error("Channel index write not stored");

        a_each_enable_store: assert property (
            @(posedge CLK) disable iff (!RST_B)
            s_sub_write(k) |=> st.sub[k][rtse_pkg::SUB_ENABLE_BIT]
                == $past(PWDATA[rtse_pkg::SUB_ENABLE_BIT]))
            else $error("Subscription enable write not stored");

        // A write to one task must never disturb another
        a_each_sub_hold: assert property (
            @(posedge CLK) disable iff (!RST_B)
            !(wr && sub_hit && (task_idx == 4'(k))) |=> $stable(st.sub[k]))
            else $error("Subscription changed without a write to it");

        a_each_read_data: assert property (
            @(posedge CLK) disable iff (!RST_B)
            s_sub_read(k) |=> PREADY && !PSLVERR && (PRDATA == $past(st.sub[k])))
            else $error("Subscription read returned wrong data");

        // Write walk: setup, access with the answer, then the bus goes quiet
        a_each_write_walk: assert property (
            @(posedge CLK) disable iff (!RST_B)
            s_sub_read(k) ##1 s_sub_write(k) |=> !PREADY
                && (st.sub[k][rtse_pkg::CHANNEL_INDEX_W-1:0]
                    == $past(PWDATA[rtse_pkg::CHANNEL_INDEX_W-1:0])))
            else $error("Subscription write walk broken");

        a_each_reset_value: assert property (
            @(posedge CLK)
            !RST_B |=> (st.sub[k] == rtse_pkg::SUB_RESET) && !TASK_TRIGGER[k])
            else $error("Subscription or trigger not cleared by reset");
    end

    // Event flags stand until software clears them
    a_rampup_flag_hold: assert property (
        @(posedge CLK) disable iff (!RST_B)
        st.rampup_flag && !wr |=> st.rampup_flag)
        else $error("Ramp-up flag dropped without a clear");

    a_address_flag_hold: assert property (
        @(posedge CLK) disable iff (!RST_B)
        st.address_flag && !wr |=> st.address_flag)
        else $error("Address flag dropped without a clear");

    a_rampup_flag_clear: assert property (
        @(posedge CLK) disable iff (!RST_B)
        s_rampup_clear |=> !st.rampup_flag)
        else $error("Ramp-up flag not cleared by writing zero");

    a_address_flag_clear: assert property (
        @(posedge CLK) disable iff (!RST_B)
        s_address_clear |=> !st.address_flag)
        else $error("Address flag not cleared by writing zero");

    // The flags are plain read-write bits, so software may also set them
    a_rampup_write_one: assert property (
        @(posedge CLK) disable iff (!RST_B)
        wr && (PADDR == rtse_pkg::OFF_RAMPUP_DONE_EVENT)
            && PWDATA[rtse_pkg::EVENT_FLAG_BIT] |=> st.rampup_flag)
        else $error("Ramp-up flag not set by writing one");

    a_address_write_one: assert property (
        @(posedge CLK) disable iff (!RST_B)
        wr && (PADDR == rtse_pkg::OFF_ADDRESS_PASSED_EVENT)
            && PWDATA[rtse_pkg::EVENT_FLAG_BIT] |=> st.address_flag)
        else $error("Address flag not set by writing one");

    a_address_no_spurious: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !st.address_flag && !ADDRESS_PASSED && !wr |=> !st.address_flag)
        else $error("Address flag rose without event");

    // Flag reads return the flag alone; no other bit is implemented
    a_rampup_read_back: assert property (
        @(posedge CLK) disable iff (!RST_B)
        s_flag_read(rtse_pkg::OFF_RAMPUP_DONE_EVENT) |=> PREADY
            && (PRDATA == (32'($past(st.rampup_flag)) << rtse_pkg::EVENT_FLAG_BIT)))
        else $error("Ramp-up flag read returned wrong data");

    a_address_read_back: assert property (
        @(posedge CLK) disable iff (!RST_B)
        s_flag_read(rtse_pkg::OFF_ADDRESS_PASSED_EVENT) |=> PREADY
            && (PRDATA == (32'($past(st.address_flag)) << rtse_pkg::EVENT_FLAG_BIT)))
        else $error("Address flag read returned wrong data");

    // Interrupt status follows the same events as the flags but is cleared apart
    a_status_rampup_set: assert property (
        @(posedge CLK) disable iff (!RST_B)
        RAMPUP_DONE |=> st.int_status[rtse_pkg::INT_RAMPUP_BIT])
        else $error("Ramp-up status bit not set");

    a_status_address_set: assert property (
        @(posedge CLK) disable iff (!RST_B)
        ADDRESS_PASSED |=> st.int_status[rtse_pkg::INT_ADDRESS_BIT])
        else $error("Address status bit not set");

    // The level output is registered, so it tracks the stored status and mask
    a_irq_level: assert property (
        @(posedge CLK) disable iff (!RST_B)
        IRQ == (|(st.int_status & st.int_mask)))
        else $error("Interrupt level does not match status and mask");

    // Anything outside the map answers with an error and zero data
    a_unmapped_error: assert property (
        @(posedge CLK) disable iff (!RST_B)
        setup && !sub_hit && (PADDR != rtse_pkg::OFF_RAMPUP_DONE_EVENT)
            && (PADDR != rtse_pkg::OFF_ADDRESS_PASSED_EVENT)
            && (PADDR != rtse_pkg::OFF_INT_STATUS) && (PADDR != rtse_pkg::OFF_INT_MASK)
            |=> PREADY && PSLVERR && (PRDATA == 32'h0000_0000))
        else $error("Unmapped access not refused");

    a_unaligned_error: assert property (
        @(posedge CLK) disable iff (!RST_B)
        setup && (PADDR[1:0] != 2'h0) |=> PREADY && PSLVERR)
        else $error("Unaligned access not refused");

    // Read data is zero outside the access cycle, so a stale word never leaks
    a_prdata_idle_zero: assert property (
        @(posedge CLK) disable iff (!RST_B)
        !PREADY |-> (PRDATA == 32'h0000_0000) && !PSLVERR)
        else $error("Read data or error shown outside access cycle");

    a_reset_outputs_zero: assert property (
        @(posedge CLK)
        !RST_B |=> !PREADY && !PSLVERR && !IRQ && (PRDATA == 32'h0000_0000))
        else $error("Outputs not cleared by reset");

endmodule : rtse_bank

// >>> tb/rtse_chan_model.sv
// Event interconnect model: one-cycle broadcast pulse on a chosen channel
`timescale 1ns/10ps
module rtse_chan_model (
    // Command from the bench
    input  wire logic [7:0]   CH,
    input  wire logic         FIRE,
    // Broadcast channels
    output logic      [255:0] CHANNEL_PULSE
);
    // Only one channel fires at a time, so a wrong index cannot hide behind another
    always_comb CHANNEL_PULSE = FIRE ? (256'h1 << CH) : 256'h0;
endmodule : rtse_chan_model

// >>> tb/testbench.sv
// Self-checking bench for the task subscription and event flag bank
`timescale 1ns/10ps
module testbench;
    logic        CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, FIRE = 0;
    logic        RAMPUP_DONE = 0, ADDRESS_PASSED = 0, PREADY, PSLVERR, IRQ, er;
    logic [11:0] PADDR = 12'h000, TASK_TRIGGER;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, rd;
    logic [7:0]  CH = 8'h00, c;
    logic [255:0] CHANNEL_PULSE;
    int          bad_count = 0, checks = 0;
    rtse_chan_model chan (.CH(CH), .FIRE(FIRE), .CHANNEL_PULSE(CHANNEL_PULSE));
    rtse_bank uut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CHANNEL_PULSE(CHANNEL_PULSE), .RAMPUP_DONE(RAMPUP_DONE),
        .ADDRESS_PASSED(ADDRESS_PASSED), .TASK_TRIGGER(TASK_TRIGGER), .IRQ(IRQ));
    initial forever #2.5 CLK = ~CLK;
    task final_report;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request held until the edge where PREADY is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0; PENABLE <= 0;
        if (n >= 20) begin
            bad_count++;
            final_report();
        end
    endtask : apb
    // One-cycle pulse: 0 channel, 1 ramp-up done, 2 address passed; caller samples next edge
    task fire(input int src, input logic [7:0] ch);
        @(posedge CLK);
        CH <= ch; FIRE <= (src == 0); RAMPUP_DONE <= (src == 1); ADDRESS_PASSED <= (src == 2);
        @(posedge CLK);
        FIRE <= 0; RAMPUP_DONE <= 0; ADDRESS_PASSED <= 0;
        @(posedge CLK);
    endtask : fire
    initial begin
        repeat (20) @(posedge CLK);
        RST_B <= 1;
        for (int i = 0; i < 12; i++) begin
            apb(0, rtse_pkg::OFF_SUB_FIRST + 12'(4 * i), 32'h0000_0000);
            chk(rd, rtse_pkg::SUB_RESET);
            c = (i == 11) ? 8'hFF : 8'(i * 23);
            // Reserved bits written as ones must read back as zero
            apb(1, rtse_pkg::OFF_SUB_FIRST + 12'(4 * i), 32'hFFFF_FF00 | 32'(c));
            apb(0, rtse_pkg::OFF_SUB_FIRST + 12'(4 * i), 32'h0000_0000);
            chk(rd, 32'h8000_0000 | 32'(c));
            fire(0, c);
            chk(32'(TASK_TRIGGER), 32'h0000_0001 << i);
        end
        apb(1, rtse_pkg::OFF_SUB_FIRST, 32'h0000_0000);
        fire(0, 8'h00);
        chk(32'(TASK_TRIGGER), 32'h0000_0000);
        apb(1, rtse_pkg::OFF_INT_MASK, 32'h0000_0003);
        fire(1, 8'h00);
        chk(32'(IRQ), 32'h0000_0001);
        apb(0, rtse_pkg::OFF_RAMPUP_DONE_EVENT, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(0, rtse_pkg::OFF_ADDRESS_PASSED_EVENT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1, rtse_pkg::OFF_RAMPUP_DONE_EVENT, 32'h0000_0000);
        apb(0, rtse_pkg::OFF_RAMPUP_DONE_EVENT, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        fire(2, 8'h00);
        apb(0, rtse_pkg::OFF_ADDRESS_PASSED_EVENT, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(0, rtse_pkg::OFF_INT_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        apb(1, rtse_pkg::OFF_INT_STATUS, 32'h0000_0003);
        apb(0, rtse_pkg::OFF_INT_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(32'(IRQ), 32'h0000_0000);
        apb(1, rtse_pkg::OFF_INT_MASK, 32'h0000_0000);
        fire(1, 8'h00);
        chk(32'(IRQ), 32'h0000_0000);
        apb(0, 12'h200, 32'h0000_0000);
        chk(32'(er), 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        final_report();
    end
endmodule : testbench
